/* loop_code_ais_detect_params.svh */
`ifndef LOOP_CODE_AIS_DETECT_PARAMS_SVH
`define LOOP_CODE_AIS_DETECT_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------------
`define LCA_CTRL_IDX       8'h04
`define LCA_STATUS_IDX     8'h05
`define LCA_CTRL_ADDR      8'h10
`define LCA_STATUS_ADDR    8'h14

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define LCA_MODE_LO_BIT    0
`define LCA_MODE_HI_BIT    1
`define LCA_LOS_IE_BIT     2
`define LCA_AIS_IE_BIT     3
`define LCA_LOOP_IE_BIT    4
`define LCA_CTRL_RESET     5'h00

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define LCA_ST_LOS_BIT     1
`define LCA_ST_AIS_BIT     2
`define LCA_ST_LOOP_BIT    3
`define LCA_STATUS_RESET   8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define LCA_HOLD_S         5
`define LCA_CLK_HZ         40000000
`define LCA_HOLD_CYC       (`LCA_HOLD_S * `LCA_CLK_HZ)
`define LCA_AIS_ONES       2048
`define LCA_UP_PERIOD      5
`define LCA_DOWN_PERIOD    3

`endif

/* loop_code_ais_detect_pkg.sv */
package loop_code_ais_detect_pkg;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_WAIT_UP = 2'b01,
    ST_LOOPED  = 2'b10
  } lc_state_e;

endpackage

/* loop_code_ais_detect.sv */
`timescale 1ns/1ps
`include "loop_code_ais_detect_params.svh"
`default_nettype none

module loop_code_ais_detect
#(
  parameter int unsigned HOLD_CYCLES = `LCA_HOLD_CYC,
  parameter int unsigned AIS_ONES    = `LCA_AIS_ONES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rx_bit_i,
  input  wire logic        rx_strobe_i,
  input  wire logic        signal_loss_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  output logic             remote_loopback_o,
  output logic             loop_code_irq_o,
  output logic             all_ones_alarm_irq_o,
  output logic             signal_loss_irq_o
);
  import loop_code_ais_detect_pkg::*;

  localparam int CW = 28;
  localparam int AW = 16;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << CW)) begin : g_hold_chk
    $error("HOLD_CYCLES out of range");
  end
  if (AIS_ONES < 1 || AIS_ONES >= (1 << AW)) begin : g_ais_chk
    $error("AIS_ONES out of range");
  end

  localparam logic [CW-1:0] HOLD_MAX = CW'(HOLD_CYCLES);
  localparam logic [AW-1:0] AIS_MAX  = AW'(AIS_ONES);

  // --------------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------------
  logic [4:0]  ctrl_q;
  logic [4:0]  ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0]  status;
  logic        loop_status_q;
  logic        ais_status_q;

  logic mode_lo;
  logic mode_hi;
  assign mode_lo = ctrl_q[`LCA_MODE_LO_BIT];
  assign mode_hi = ctrl_q[`LCA_MODE_HI_BIT];

  always_comb begin
    status = `LCA_STATUS_RESET;
    status[`LCA_ST_LOOP_BIT] = loop_status_q;
    status[`LCA_ST_AIS_BIT]  = ais_status_q;
    status[`LCA_ST_LOS_BIT]  = signal_loss_i;
    ctrl_d  = ctrl_q;
    rdata_d = 32'h0000_0000;
    if (we_i && addr_i == `LCA_CTRL_ADDR) begin
      ctrl_d = wdata_i[4:0];
    end
    if (re_i) begin
      case (addr_i)
        `LCA_CTRL_ADDR:   rdata_d = {27'h0000000, ctrl_q};
        `LCA_STATUS_ADDR: rdata_d = {24'h000000, status};
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= `LCA_CTRL_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // --------------------------------------------------------------------------
  // pattern window
  // --------------------------------------------------------------------------
  // a run of the pattern is exactly one mark in every window of one period,
  // which accepts any phase of the repeating code
  logic [4:0] win_q;
  logic [4:0] win_d;
  logic [2:0] fill_q;
  logic [2:0] fill_d;
  logic       watch_up;
  logic       watch_up_q;
  logic       watch_up_d;
  logic       active;
  logic       active_q;
  logic       active_d;
  logic       present;
  logic       restart;
  logic [2:0] ones5;
  logic [1:0] ones3;
  lc_state_e  state_q;
  lc_state_e  state_d;

  always_comb begin
    ones5 = 3'(win_q[0]) + 3'(win_q[1]) + 3'(win_q[2]) + 3'(win_q[3]) + 3'(win_q[4]);
    ones3 = 2'(win_q[0]) + 2'(win_q[1]) + 2'(win_q[2]);
    active = mode_hi | mode_lo;
    // taken from the registered state: the next state itself depends on the pattern seen
    if (mode_hi && mode_lo) begin
      watch_up = (state_q != ST_LOOPED);
    end else begin
      watch_up = !mode_hi;
    end
    // entering automatic mode starts a fresh measurement, not one left over from manual
    restart = (watch_up != watch_up_q) || (active != active_q) ||
              (mode_hi && mode_lo && state_q == ST_OFF);
    if (watch_up) begin
      present = (fill_q >= 3'(`LCA_UP_PERIOD)) && (ones5 == 3'h1);
    end else begin
      present = (fill_q >= 3'(`LCA_DOWN_PERIOD)) && (ones3 == 2'h1);
    end
  end

  always_comb begin
    win_d      = win_q;
    fill_d     = fill_q;
    watch_up_d = watch_up;
    active_d   = active;
    if (restart) begin
      fill_d = 3'h0;
    end else if (rx_strobe_i) begin
      win_d = {win_q[3:0], rx_bit_i};
      if (fill_q < 3'(`LCA_UP_PERIOD)) begin
        fill_d = fill_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q      <= 5'h00;
      fill_q     <= 3'h0;
      watch_up_q <= 1'b1;
      active_q   <= 1'b0;
    end else begin
      win_q      <= win_d;
      fill_q     <= fill_d;
      watch_up_q <= watch_up_d;
      active_q   <= active_d;
    end
  end

  // --------------------------------------------------------------------------
  // duration counter
  // --------------------------------------------------------------------------
  logic [CW-1:0] dur_q;
  logic [CW-1:0] dur_d;
  logic          held;

  // a stale window must not count right after the watched pattern swaps
  assign held = present && !restart && (dur_q == HOLD_MAX);

  always_comb begin
    dur_d = dur_q;
    if (!present || restart || !active) begin
      dur_d = '0;
    end else if (dur_q != HOLD_MAX) begin
      dur_d = dur_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dur_q <= '0;
    end else begin
      dur_q <= dur_d;
    end
  end

  // --------------------------------------------------------------------------
  // loop code status and automatic loopback
  // --------------------------------------------------------------------------
  logic loop_status_d;
  logic loopback_q;
  logic loopback_d;
  logic loop_irq_q;
  logic loop_irq_d;

  always_comb begin
    state_d       = state_q;
    loop_status_d = loop_status_q;
    loopback_d    = loopback_q;
    if (mode_hi && mode_lo) begin
      case (state_q)
        ST_OFF: begin
          state_d       = ST_WAIT_UP;
          loop_status_d = 1'b0;
          loopback_d    = 1'b0;
        end
        ST_WAIT_UP: begin
          if (held) begin
            state_d       = ST_LOOPED;
            loop_status_d = 1'b1;
            loopback_d    = 1'b1;
          end
        end
        ST_LOOPED: begin
          loop_status_d = 1'b1;
          if (held) begin
            state_d       = ST_WAIT_UP;
            loop_status_d = 1'b0;
            loopback_d    = 1'b0;
          end
        end
        default: begin
          state_d = ST_OFF;
        end
      endcase
    end else begin
      state_d    = ST_OFF;
      loopback_d = 1'b0;
      if (active) begin
        // manual modes differ only in which pattern is watched
        loop_status_d = present && (held || loop_status_q);
      end else begin
        loop_status_d = 1'b0;
      end
    end
    loop_irq_d = ctrl_q[`LCA_LOOP_IE_BIT] && (loop_status_d != loop_status_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q       <= ST_OFF;
      loop_status_q <= 1'b0;
      loopback_q    <= 1'b0;
      loop_irq_q    <= 1'b0;
    end else begin
      state_q       <= state_d;
      loop_status_q <= loop_status_d;
      loopback_q    <= loopback_d;
      loop_irq_q    <= loop_irq_d;
    end
  end

  assign remote_loopback_o = loopback_q;
  assign loop_code_irq_o   = loop_irq_q;

  // --------------------------------------------------------------------------
  // all-ones alarm and signal loss
  // --------------------------------------------------------------------------
  // the alarm status is meaningful only with the framer bypassed; software
  // otherwise reads the framer's own alarm state
  logic [AW-1:0] ones_q;
  logic [AW-1:0] ones_d;
  logic          ais_status_d;
  logic          ais_irq_q;
  logic          ais_irq_d;
  logic          los_q;
  logic          los_irq_q;
  logic          los_irq_d;

  always_comb begin
    ones_d       = ones_q;
    ais_status_d = ais_status_q;
    if (rx_strobe_i) begin
      if (!rx_bit_i) begin
        ones_d       = '0;
        ais_status_d = 1'b0;
      end else if (ones_q != AIS_MAX) begin
        ones_d = ones_q + AW'(1);
      end
      if (rx_bit_i && ones_q >= AIS_MAX - AW'(1)) begin
        ais_status_d = 1'b1;
      end
    end
    ais_irq_d = ctrl_q[`LCA_AIS_IE_BIT] && (ais_status_d != ais_status_q);
    los_irq_d = ctrl_q[`LCA_LOS_IE_BIT] && (signal_loss_i != los_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ones_q       <= '0;
      ais_status_q <= 1'b0;
      ais_irq_q    <= 1'b0;
      los_q        <= 1'b0;
      los_irq_q    <= 1'b0;
    end else begin
      ones_q       <= ones_d;
      ais_status_q <= ais_status_d;
      ais_irq_q    <= ais_irq_d;
      los_q        <= signal_loss_i;
      los_irq_q    <= los_irq_d;
    end
  end

  assign all_ones_alarm_irq_o = ais_irq_q;
  assign signal_loss_irq_o    = los_irq_q;

endmodule

`default_nettype wire

/* loop_code_ais_detect_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module loop_code_ais_detect_asserts #(
  parameter int unsigned HOLD_CYCLES = 50,
  parameter int unsigned AIS_ONES    = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        rx_bit_i,
  input wire logic        rx_strobe_i,
  input wire logic        signal_loss_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        we_i,
  input wire logic        re_i,
  input wire logic [31:0] rdata_o,
  input wire logic        remote_loopback_o,
  input wire logic        loop_code_irq_o,
  input wire logic        all_ones_alarm_irq_o,
  input wire logic        signal_loss_irq_o
);
  logic [4:0]  ctrl_q, ctrl_d;
  int unsigned lb_q, lb_d, one_q, one_d;
  // ----
  // shadow of control and all-ones run
  // ----
  always_comb begin
    ctrl_d = (we_i && addr_i == 8'h10) ? wdata_i[4:0] : ctrl_q;
    lb_d   = remote_loopback_o ? lb_q + 1 : 0;
    one_d  = one_q;
    if (rx_strobe_i) begin
      one_d = !rx_bit_i ? 0 : ((one_q < AIS_ONES) ? one_q + 1 : one_q);
    end
  end
  always_ff @(posedge clk_i) begin
    ctrl_q <= rst_i ? 5'h00 : ctrl_d;
    lb_q   <= rst_i ? 0 : lb_d;
    one_q  <= rst_i ? 0 : one_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence auto_on;
    ctrl_q[1:0] == 2'h3 && $past(ctrl_q[1:0]) == 2'h3;
  endsequence
  sequence loop_ie_on;
    ctrl_q[4] && $past(ctrl_q[4]);
  endsequence
  lb_manual_off_a: assert property (ctrl_q[1:0] != 2'h3 && $past(ctrl_q[1:0]) != 2'h3 |-> !remote_loopback_o)
    else $error("loopback active outside automatic mode");
  lb_rise_irq_a: assert property (auto_on ##0 loop_ie_on ##0 $rose(remote_loopback_o) |-> loop_code_irq_o)
    else $error("loopback rise without loop status interrupt");
  lb_fall_irq_a: assert property (auto_on ##0 loop_ie_on ##0 $fell(remote_loopback_o) |-> loop_code_irq_o)
    else $error("loopback removal without loop status interrupt");
  lb_min_hold_a: assert property (auto_on ##0 $fell(remote_loopback_o) |-> lb_q >= HOLD_CYCLES)
    else $error("loopback removed too early");
  loop_irq_off_a: assert property (!ctrl_q[4] && !$past(ctrl_q[4]) |-> !loop_code_irq_o)
    else $error("loop interrupt while disabled");
  ais_irq_a: assert property (ctrl_q[3] && $past(ctrl_q[3]) && $changed(one_q == AIS_ONES) |-> ##[0:1] all_ones_alarm_irq_o)
    else $error("alarm change without interrupt");
  ais_irq_off_a: assert property (!ctrl_q[3] && !$past(ctrl_q[3]) |-> !all_ones_alarm_irq_o)
    else $error("alarm interrupt while disabled");
  los_irq_a: assert property (ctrl_q[2] && $past(ctrl_q[2]) && $changed(signal_loss_i) |-> ##[0:2] signal_loss_irq_o)
    else $error("signal loss change without interrupt");
  los_irq_off_a: assert property (!ctrl_q[2] && !$past(ctrl_q[2]) |-> !signal_loss_irq_o)
    else $error("signal loss interrupt while disabled");
  auto_status_a: assert property (auto_on ##1 ($past(re_i) && $past(addr_i) == 8'h14)
                                  |-> rdata_o[3] == $past(remote_loopback_o))
    else $error("loop status differs from loopback");
endmodule
`default_nettype wire

/* line_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module line_far_end (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] pat_i,
  input  wire logic       slow_i,
  output logic            rx_bit_o,
  output logic            rx_strobe_o
);
  int unsigned k;
  logic        nxt;
  always_comb begin
    case (pat_i)
      2'h1:    nxt = (k % 5) == 4;
      2'h2:    nxt = (k % 3) == 2;
      2'h3:    nxt = 1'b1;
      default: nxt = 1'b0;
    endcase
  end
  // between strobes the line shows the inverse so a stale bit is never taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_strobe_o <= 1'b0;
      rx_bit_o    <= 1'b0;
      k           <= 0;
    end else if (slow_i && rx_strobe_o) begin
      rx_strobe_o <= 1'b0;
      rx_bit_o    <= ~rx_bit_o;
    end else begin
      rx_strobe_o <= 1'b1;
      rx_bit_o    <= nxt;
      k           <= k + 1;
    end
  end
endmodule
`default_nettype wire

/* loop_code_ais_detect_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module loop_code_ais_detect_tb_top;
  localparam int unsigned HOLD = 50;
  logic        clk_i, rst_i, rx_bit_i, rx_strobe_i, signal_loss_i, we_i, re_i, slow;
  logic        remote_loopback_o, loop_code_irq_o, all_ones_alarm_irq_o, signal_loss_irq_o;
  logic [1:0]  pat;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  int          n_errors, comparisons, n_lirq, n_airq;
  loop_code_ais_detect #(.HOLD_CYCLES(HOLD), .AIS_ONES(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .rx_bit_i(rx_bit_i), .rx_strobe_i(rx_strobe_i),
    .signal_loss_i(signal_loss_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .remote_loopback_o(remote_loopback_o), .loop_code_irq_o(loop_code_irq_o),
    .all_ones_alarm_irq_o(all_ones_alarm_irq_o), .signal_loss_irq_o(signal_loss_irq_o));
  line_far_end far (.clk_i(clk_i), .rst_i(rst_i), .pat_i(pat), .slow_i(slow),
                    .rx_bit_o(rx_bit_i), .rx_strobe_o(rx_strobe_i));
  function automatic logic [31:0] st_exp(input logic [1:0] m, input logic [1:0] p, input logic l);
    st_exp = {28'h0, (m == 2'h1 && p == 2'h1) || (m == 2'h2 && p == 2'h2), p == 2'h3, l, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (loop_code_irq_o === 1'b1) n_lirq++;
    if (all_ones_alarm_irq_o === 1'b1) n_airq++;
  end
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #(25 * 20000);
    n_errors++;
    end_sim();
  end
  initial begin
    {rst_i, signal_loss_i, we_i, re_i, slow, pat, addr_i, wdata_i} = {1'b1, 46'h0};
    void'($urandom(32'h3C09A2DA));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10, d);
    chk("ctrl_reset", 32'h0, d);
    rd({2'h3, 6'($urandom)}, d);
    chk("unmapped", 32'h0, d);
    wr(8'h14, 32'hFF);
    rd(8'h14, d);
    chk("status_ro", 32'h0, d);
    for (int m = 1; m < 3; m++) begin
      for (int p = 0; p < 4; p++) begin
        signal_loss_i <= 1'($urandom_range(1, 0));
        slow          <= 1'($urandom_range(1, 0));
        wr(8'h10, {27'h0, 3'h7, 2'(m)});
        pat <= 2'(p);
        repeat (2 * HOLD + 20) @(posedge clk_i);
        rd(8'h14, d);
        chk("status", st_exp(2'(m), 2'(p), signal_loss_i), d);
        pat <= 2'h0;
        repeat (14) @(posedge clk_i);
        rd(8'h14, d);
        chk("status_off", st_exp(2'(m), 2'h0, signal_loss_i), d);
      end
    end
    chk("ais_irqs", 32'd4, n_airq);
    // ----
    // pattern break restarts the hold, then automatic mode
    // ----
    {slow, signal_loss_i} <= 2'h0;
    wr(8'h10, 32'h1D);
    rd(8'h10, d);
    chk("ctrl_rw", 32'h1D, d);
    pat <= 2'h1;
    repeat (HOLD - 15) @(posedge clk_i);
    pat <= 2'h0;
    repeat (8) @(posedge clk_i);
    pat <= 2'h1;
    repeat (HOLD - 15) @(posedge clk_i);
    rd(8'h14, d);
    chk("restart", 32'h0, d);
    repeat (HOLD) @(posedge clk_i);
    wr(8'h10, 32'h1F);
    rd(8'h14, d);
    chk("auto_entry", 32'h0, d);
    n_lirq = 0;
    repeat (2 * HOLD) @(posedge clk_i);
    rd(8'h14, d);
    chk("auto_up", 32'h9, {d[31:1], remote_loopback_o});
    pat <= 2'h0;
    repeat (2 * HOLD) @(posedge clk_i);
    rd(8'h14, d);
    chk("auto_keep", 32'h9, {d[31:1], remote_loopback_o});
    for (int i = 0; i < 2; i++) begin
      pat <= 2'h2;
      repeat (HOLD - 10) @(posedge clk_i);
      pat <= 2'h0;
      repeat (10) @(posedge clk_i);
    end
    chk("down_short", 32'h1, {31'h0, remote_loopback_o});
    pat <= 2'h2;
    repeat (2 * HOLD) @(posedge clk_i);
    chk("down_held", 32'h0, {31'h0, remote_loopback_o});
    chk("loop_irqs", 32'd2, n_lirq);
    repeat (6) begin
      pat  <= 2'($urandom_range(3, 1));
      slow <= 1'($urandom_range(1, 0));
      repeat ($urandom_range(HOLD - 15, 5)) @(posedge clk_i);
      pat <= 2'h0;
      repeat (14) @(posedge clk_i);
    end
    chk("lb_random", 32'h0, {31'h0, remote_loopback_o});
    end_sim();
  end
endmodule
bind loop_code_ais_detect loop_code_ais_detect_asserts #(.HOLD_CYCLES(HOLD_CYCLES), .AIS_ONES(AIS_ONES)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .rx_bit_i(rx_bit_i), .rx_strobe_i(rx_strobe_i),
  .signal_loss_i(signal_loss_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
  .rdata_o(rdata_o), .remote_loopback_o(remote_loopback_o), .loop_code_irq_o(loop_code_irq_o),
  .all_ones_alarm_irq_o(all_ones_alarm_irq_o), .signal_loss_irq_o(signal_loss_irq_o));
`default_nettype wire
